// ---- hw/sarctl_pkg.sv ----
package sarctl_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  MAIN_CONTROL_OFS = 8'h00;
  localparam logic [7:0]  QPTR_BASE_OFS    = 8'h10;
  localparam logic [15:0] MAIN_CONTROL_RST = 16'h0000;
  localparam logic [15:0] QPTR_RST         = 16'h0000;
  localparam int unsigned QPTR_COUNT       = 4;

  // ---------------------------------------------------------------
  // field constants
  // ---------------------------------------------------------------
  localparam logic [2:0]  VP_COUNT_MAX     = 3'h5;
  localparam logic [17:0] NNI_FILTER_MASK  = 18'h3_ffff;
  localparam logic [17:0] UNI_FILTER_MASK  = 18'h0_3fff;
  localparam logic [15:0] F4_SEG_VCI       = 16'h0003;
  localparam logic [15:0] F4_E2E_VCI       = 16'h0004;
  localparam int unsigned PTI_MGMT_BIT     = 2;
  localparam logic [9:0]  CRC10_POLY       = 10'h233;

  // main control register, bit 15 down to bit 0
  typedef struct packed {
    logic       ready_irq_on_packet_end;
    logic [2:0] vp_bit_count;
    logic [1:0] filter_upper_bits;
    logic       network_interface_select;
    logic       discard_mgmt_cells;
    logic       mgmt_cell_crc_check;
    logic       descriptor_auto_update;
    logic       test_loop;
    logic       token_restart;
    logic       init_complete;
    logic       soft_reset;
    logic       queue_pointer_write_enable;
    logic       keep_frame_length;
  } sarctl_ctrl_s;

  typedef struct packed {
    logic [17:0] addr;
    logic [11:0] vpi;
    logic [15:0] vci;
    logic [2:0]  pti;
  } sarctl_hdr_s;

  typedef struct packed {
    logic       soc;
    logic [7:0] data;
  } sarctl_cell_s;

endpackage

// ---- hw/sarctl_filt.sv ----
module sarctl_filt
  import sarctl_pkg::*;
(
  input  sarctl_ctrl_s ctrl,
  input  wire  [15:0]  filter_low,
  input  sarctl_hdr_s  hdr,
  output logic         match,
  output logic         discard,
  output logic [4:0]   map_vp
);

  logic [17:0] filt_val;
  logic [17:0] cmp_mask;
  logic [2:0]  vp_n;
  logic        is_f4;
  logic        is_user;

  assign filt_val = {ctrl.filter_upper_bits, filter_low};
  assign cmp_mask = ctrl.network_interface_select ? NNI_FILTER_MASK
                                                  : UNI_FILTER_MASK;
  assign match    = ((hdr.addr ^ filt_val) & cmp_mask) == 18'h0_0000;

  // illegal codes saturate at the top of the valid range
  assign vp_n = (ctrl.vp_bit_count > VP_COUNT_MAX) ? VP_COUNT_MAX
                                                   : ctrl.vp_bit_count;

  genvar i;
  generate
    for (i = 0; i < 5; i++) begin : g_vp
      assign map_vp[i] = hdr.vpi[i] & (vp_n > 3'(i));
    end
  endgenerate

  assign is_f4   = (hdr.vci == F4_SEG_VCI) || (hdr.vci == F4_E2E_VCI);
  assign is_user = !hdr.pti[PTI_MGMT_BIT];
  assign discard = ctrl.discard_mgmt_cells & !is_user & !is_f4;

endmodule

// ---- hw/sarctl_crc10.sv ----
module sarctl_crc10
  import sarctl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       byte_valid,
  input  wire logic       first,
  input  wire logic       last,
  input  wire logic [7:0] data,
  output logic            done,
  output logic            ok
);

  logic [9:0] crc_r;
  logic [9:0] crc_nxt;

  // ---------------------------------------------------------------
  // bytewise remainder, msb first; zero over payload plus check field
  // ---------------------------------------------------------------
  always_comb begin
    crc_nxt = first ? 10'h000 : crc_r;
    for (int b = 7; b >= 0; b--) begin
      if (crc_nxt[9] ^ data[b]) begin
        crc_nxt = {crc_nxt[8:0], 1'b0} ^ CRC10_POLY;
      end else begin
        crc_nxt = {crc_nxt[8:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_r <= 10'h000;
    end else if (clr) begin
      crc_r <= 10'h000;
    end else if (byte_valid) begin
      crc_r <= crc_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      ok   <= 1'b0;
    end else begin
      done <= byte_valid & last & !clr;
      if (byte_valid & last) begin
        ok <= (crc_nxt == 10'h000);
      end
    end
  end

endmodule

// ---- hw/sarctl_top.sv ----
// Our own choices: the APB interface to the registers and the register addresses.
module sarctl_top
  import sarctl_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        STREAM_MODE,
  input  wire logic        PKT_END,
  input  wire logic        FREQ_IRQ,
  output logic             READY_IRQ,
  input  wire logic [15:0] FILTER_LOW,
  input  wire logic        RX_HDR_VALID,
  input  sarctl_hdr_s      RX_HDR,
  output logic             RX_ACCEPT,
  output logic             RX_DROP,
  output logic [4:0]       RX_MAP_VP,
  input  wire logic        OAM_BYTE_VALID,
  input  wire logic        OAM_FIRST,
  input  wire logic        OAM_LAST,
  input  wire logic [7:0]  OAM_BYTE,
  output logic             OAM_CRC_ERR,
  input  wire logic        DESC_OPEN,
  input  wire logic [15:0] DESC_BUF_SIZE,
  output logic             DESC_WR,
  output logic [15:0]      DESC_REMAIN,
  output logic [15:0]      DESC_RECEIVED,
  input  sarctl_cell_s     TX_CELL,
  input  sarctl_cell_s     RX_CELL_PIN,
  output sarctl_cell_s     RX_CELL,
  output logic             LOOP_CLK_SEL,
  output logic             TOKEN_OUT,
  output logic             SOFT_RESET,
  output logic             INIT_DONE,
  output logic             KEEP_FRAME_LEN,
  output logic             QPTR_WR_EN,
  output logic [3:0][15:0] QPTR
);

  sarctl_ctrl_s  ctrl_r;
  logic [15:0]   qptr_r [QPTR_COUNT];
  logic          soft_rst_r;
  logic          token_r;
  logic [31:0]   rdata_r;
  logic [31:0]   rdata_nxt;
  logic          err_r;
  logic          err_nxt;
  logic          setup;
  logic          acc;
  logic          wr_acc;
  logic          hit_main;
  logic          hit_qptr;
  logic [1:0]    qidx;
  sarctl_cell_s  pin_s1_r;
  sarctl_cell_s  pin_s2_r;
  sarctl_cell_s  rx_cell_r;
  logic          irq_r;
  logic          accept_r;
  logic          drop_r;
  logic [4:0]    map_vp_r;
  logic          f_match;
  logic          f_discard;
  logic [4:0]    f_map_vp;
  logic          crc_done;
  logic          crc_ok;
  logic          crc_err_r;
  logic          desc_wr_r;
  logic [15:0]   desc_rem_r;
  logic [15:0]   desc_rcv_r;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign setup    = PSEL & !PENABLE;
  assign acc      = PSEL & PENABLE;
  assign wr_acc   = acc & PWRITE;
  assign hit_main = (PADDR == MAIN_CONTROL_OFS);
  assign hit_qptr = (PADDR[7:4] == QPTR_BASE_OFS[7:4]) && (PADDR[1:0] == 2'b00);
  assign qidx     = PADDR[3:2];

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    err_nxt   = 1'b0;
    if (hit_main) begin
      rdata_nxt = {16'h0000, ctrl_r};
    end else if (hit_qptr) begin
      rdata_nxt = {16'h0000, qptr_r[qidx]};
    end else begin
      err_nxt = 1'b1;
    end
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else if (setup) begin
      rdata_r <= PWRITE ? 32'h0000_0000 : rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  assign PREADY  = acc;
  assign PRDATA  = rdata_r;
  assign PSLVERR = acc & err_r;

  // ---------------------------------------------------------------
  // control register and soft reset
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_r <= MAIN_CONTROL_RST;
    end else if (soft_rst_r) begin
      ctrl_r <= MAIN_CONTROL_RST;
    end else if (wr_acc && hit_main) begin
      ctrl_r <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr_acc & hit_main & PWDATA[2];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      token_r <= 1'b0;
    end else begin
      token_r <= wr_acc & hit_main & PWDATA[4];
    end
  end

  assign SOFT_RESET     = soft_rst_r;
  assign TOKEN_OUT      = token_r;
  assign INIT_DONE      = ctrl_r.init_complete;
  assign KEEP_FRAME_LEN = ctrl_r.keep_frame_length;
  assign QPTR_WR_EN     = ctrl_r.queue_pointer_write_enable;

  // ---------------------------------------------------------------
  // queue pointers
  // ---------------------------------------------------------------
  genvar q;
  generate
    for (q = 0; q < QPTR_COUNT; q++) begin : g_qptr
      always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
          qptr_r[q] <= QPTR_RST;
        end else if (soft_rst_r) begin
          qptr_r[q] <= QPTR_RST;
        end else if (wr_acc && hit_qptr && (qidx == 2'(q)) &&
                     ctrl_r.queue_pointer_write_enable) begin
          qptr_r[q] <= PWDATA[15:0];
        end
      end
      assign QPTR[q] = qptr_r[q];
    end
  endgenerate

  // ---------------------------------------------------------------
  // cell loopback path
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= RX_CELL_PIN;
      pin_s2_r <= pin_s1_r;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_cell_r <= '0;
    end else if (soft_rst_r) begin
      rx_cell_r <= '0;
    end else begin
      rx_cell_r <= ctrl_r.test_loop ? TX_CELL : pin_s2_r;
    end
  end

  assign RX_CELL      = rx_cell_r;
  assign LOOP_CLK_SEL = ctrl_r.test_loop;

  // ---------------------------------------------------------------
  // ready queue interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_r <= 1'b0;
    end else if (soft_rst_r) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= FREQ_IRQ |
               (STREAM_MODE & PKT_END & ctrl_r.ready_irq_on_packet_end);
    end
  end

  assign READY_IRQ = irq_r;

  // ---------------------------------------------------------------
  // receive filter and discard
  // ---------------------------------------------------------------
  sarctl_filt u_filt (
    .ctrl       (ctrl_r),
    .filter_low (FILTER_LOW),
    .hdr        (RX_HDR),
    .match      (f_match),
    .discard    (f_discard),
    .map_vp     (f_map_vp)
  );

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      accept_r <= 1'b0;
      drop_r   <= 1'b0;
      map_vp_r <= 5'h00;
    end else if (soft_rst_r) begin
      accept_r <= 1'b0;
      drop_r   <= 1'b0;
      map_vp_r <= 5'h00;
    end else begin
      accept_r <= RX_HDR_VALID & f_match & !f_discard;
      drop_r   <= RX_HDR_VALID & !(f_match & !f_discard);
      if (RX_HDR_VALID) begin
        map_vp_r <= f_map_vp;
      end
    end
  end

  assign RX_ACCEPT = accept_r;
  assign RX_DROP   = drop_r;
  assign RX_MAP_VP = map_vp_r;

  // ---------------------------------------------------------------
  // management cell crc check
  // ---------------------------------------------------------------
  sarctl_crc10 u_crc (
    .clk        (CORE_CLK),
    .rst_n      (RESETN),
    .clr        (soft_rst_r),
    .byte_valid (OAM_BYTE_VALID),
    .first      (OAM_FIRST),
    .last       (OAM_LAST),
    .data       (OAM_BYTE),
    .done       (crc_done),
    .ok         (crc_ok)
  );

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      crc_err_r <= 1'b0;
    end else begin
      crc_err_r <= crc_done & !crc_ok & ctrl_r.mgmt_cell_crc_check;
    end
  end

  assign OAM_CRC_ERR = crc_err_r;

  // ---------------------------------------------------------------
  // receive descriptor auto update
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      desc_wr_r  <= 1'b0;
      desc_rem_r <= 16'h0000;
      desc_rcv_r <= 16'h0000;
    end else if (soft_rst_r) begin
      desc_wr_r  <= 1'b0;
      desc_rem_r <= 16'h0000;
      desc_rcv_r <= 16'h0000;
    end else begin
      desc_wr_r <= DESC_OPEN & ctrl_r.descriptor_auto_update;
      if (DESC_OPEN & ctrl_r.descriptor_auto_update) begin
        desc_rem_r <= DESC_BUF_SIZE;
        desc_rcv_r <= 16'h0000;
      end
    end
  end

  assign DESC_WR       = desc_wr_r;
  assign DESC_REMAIN   = desc_rem_r;
  assign DESC_RECEIVED = desc_rcv_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  ctrl_readback_a: assert property (
    (setup && !PWRITE && hit_main) |=> (PRDATA == {16'h0000, $past(ctrl_r)}))
    else $error("control readback mismatch");

  token_pulse_a: assert property (
    (wr_acc && hit_main && PWDATA[4]) |=> TOKEN_OUT ##1 !TOKEN_OUT)
    else $error("token pulse not single");

  soft_reset_a: assert property (
    (wr_acc && hit_main && PWDATA[2]) |=> SOFT_RESET ##1
      (ctrl_r == MAIN_CONTROL_RST && QPTR == '0))
    else $error("soft reset did not clear state");

  qptr_lock_a: assert property (
    (!ctrl_r.queue_pointer_write_enable && !soft_rst_r) |=> (QPTR == $past(QPTR)))
    else $error("queue pointer changed while locked");

  ready_irq_a: assert property (
    (STREAM_MODE && PKT_END && ctrl_r.ready_irq_on_packet_end && !soft_rst_r)
      |=> READY_IRQ)
    else $error("no ready interrupt on packet end");

  desc_update_a: assert property (
    (DESC_OPEN && ctrl_r.descriptor_auto_update && !soft_rst_r) |=>
      (DESC_WR && DESC_REMAIN == $past(DESC_BUF_SIZE) && DESC_RECEIVED == 16'h0000))
    else $error("descriptor auto update wrong");

  loop_path_a: assert property (
    (ctrl_r.test_loop && !soft_rst_r) |=> (RX_CELL == $past(TX_CELL)))
    else $error("loopback path not taken");

  crc_gate_a: assert property (
    OAM_CRC_ERR |-> $past(ctrl_r.mgmt_cell_crc_check) && $past(crc_done))
    else $error("crc error without check enabled");

  f4_keep_a: assert property (
    (RX_HDR_VALID && f_match && !soft_rst_r &&
     (RX_HDR.vci == F4_SEG_VCI || RX_HDR.vci == F4_E2E_VCI)) |=> RX_ACCEPT)
    else $error("matching F4 cell dropped");

  filt_width_a: assert property (
    (RX_HDR_VALID && !soft_rst_r && !ctrl_r.network_interface_select &&
     RX_HDR.addr[13:0] == FILTER_LOW[13:0] &&
     !(ctrl_r.discard_mgmt_cells && RX_HDR.pti[PTI_MGMT_BIT])) |=> RX_ACCEPT)
    else $error("uni filter compared too many bits");

endmodule

// ---- tb/tb_top.sv ----
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end

module tb_top
  import sarctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic               core_clk = 1'b0;
  logic               resetn, psel, penable, pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata;
  logic               pready, pslverr, stream_mode, pkt_end, freq_irq, ready_irq;
  logic [15:0]        filter_low, desc_buf_size, desc_remain, desc_received;
  logic               rx_hdr_valid, rx_accept, rx_drop;
  sarctl_hdr_s        rx_hdr;
  logic [4:0]         rx_map_vp;
  logic               oam_byte_valid, oam_first, oam_last, oam_crc_err;
  logic [7:0]         oam_byte;
  logic               desc_open, desc_wr, loop_clk_sel, token_out, soft_reset;
  sarctl_cell_s       tx_cell, rx_cell_pin, rx_cell;
  logic               init_done, keep_frame_len, qptr_wr_en;
  logic [3:0][15:0]   qptr;
  int                 num_errors = 0;
  int                 checked = 0;
  sarctl_ctrl_s       c;

  always #12.5 core_clk = ~core_clk;

  sarctl_top i_dut (
    .CORE_CLK(core_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .STREAM_MODE(stream_mode),
    .PKT_END(pkt_end), .FREQ_IRQ(freq_irq), .READY_IRQ(ready_irq),
    .FILTER_LOW(filter_low), .RX_HDR_VALID(rx_hdr_valid), .RX_HDR(rx_hdr),
    .RX_ACCEPT(rx_accept), .RX_DROP(rx_drop), .RX_MAP_VP(rx_map_vp),
    .OAM_BYTE_VALID(oam_byte_valid), .OAM_FIRST(oam_first), .OAM_LAST(oam_last),
    .OAM_BYTE(oam_byte), .OAM_CRC_ERR(oam_crc_err), .DESC_OPEN(desc_open),
    .DESC_BUF_SIZE(desc_buf_size), .DESC_WR(desc_wr), .DESC_REMAIN(desc_remain),
    .DESC_RECEIVED(desc_received), .TX_CELL(tx_cell), .RX_CELL_PIN(rx_cell_pin),
    .RX_CELL(rx_cell), .LOOP_CLK_SEL(loop_clk_sel), .TOKEN_OUT(token_out),
    .SOFT_RESET(soft_reset), .INIT_DONE(init_done), .KEEP_FRAME_LEN(keep_frame_len),
    .QPTR_WR_EN(qptr_wr_en), .QPTR(qptr)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t bus timeout", $time);
      test_done();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 16'h0000, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask

  task automatic irq(input logic sm, input logic pe, input logic fq, input logic x);
    @(posedge core_clk);
    stream_mode <= sm;
    pkt_end <= pe;
    freq_irq <= fq;
    @(posedge core_clk);
    pkt_end <= 1'b0;
    freq_irq <= 1'b0;
    #1 `CHK(ready_irq, x)
    @(posedge core_clk);
    #1 `CHK(ready_irq, 1'b0)
  endtask

  task automatic hdr(input logic [17:0] a, input logic [2:0] pti, input logic [15:0] vci,
                     input logic acc, input logic drp, input logic [4:0] vp);
    @(posedge core_clk);
    rx_hdr_valid <= 1'b1;
    rx_hdr <= '{addr: a, vpi: 12'hfff, vci: vci, pti: pti};
    @(posedge core_clk);
    rx_hdr_valid <= 1'b0;
    #1 `CHK(rx_accept, acc)
    if (drp !== 1'bx) `CHK(rx_drop, drp)
    if (acc === 1'b1) `CHK(rx_map_vp, vp)
  endtask

  task automatic desc(input logic [15:0] sz, input logic x);
    @(posedge core_clk);
    desc_open <= 1'b1;
    desc_buf_size <= sz;
    @(posedge core_clk);
    desc_open <= 1'b0;
    #1 `CHK(desc_wr, x)
    if (x) `CHK(desc_remain, sz)
    if (x) `CHK(desc_received, 16'h0000)
  endtask

  // error pulses counted over a short window after the frame
  task automatic oam(input logic [7:0] b0, input int x);
    int hits;
    hits = 0;
    for (int i = 0; i < 48; i++) begin
      @(posedge core_clk);
      oam_byte_valid <= 1'b1;
      oam_first <= (i == 0);
      oam_last <= (i == 47);
      oam_byte <= (i == 0) ? b0 : 8'h00;
    end
    @(posedge core_clk);
    oam_byte_valid <= 1'b0;
    oam_first <= 1'b0;
    oam_last <= 1'b0;
    repeat (4) begin
      @(posedge core_clk);
      #1 if (oam_crc_err !== 1'b0) hits++;
    end
    `CHK(hits, x)
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    #(25ns * 20000);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {stream_mode, pkt_end, freq_irq, rx_hdr_valid, rx_hdr} = '0;
    {oam_byte_valid, oam_first, oam_last, oam_byte, desc_open, desc_buf_size} = '0;
    filter_low = 16'h1234;
    tx_cell = '0;
    rx_cell_pin = 9'h1c3;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    rd(MAIN_CONTROL_OFS, 32'h0000_0000, 1'b0);
    for (int i = 0; i < 4; i++) rd(8'(QPTR_BASE_OFS + 4 * i), 32'h0000_0000, 1'b0);
    wr(MAIN_CONTROL_OFS, 16'hdfeb);
    rd(MAIN_CONTROL_OFS, 32'h0000_dfeb, 1'b0);
    `CHK({init_done, keep_frame_len, qptr_wr_en, loop_clk_sel}, 4'hf)
    wr(MAIN_CONTROL_OFS, 16'h2408);
    rd(MAIN_CONTROL_OFS, 32'h0000_2408, 1'b0);
    wr(8'h40, 16'hffff);
    rd(8'h40, 32'h0000_0000, 1'b1);
    $display("test regs done");
    wr(MAIN_CONTROL_OFS, 16'h0002);
    for (int i = 0; i < 4; i++) wr(8'(QPTR_BASE_OFS + 4 * i), 16'(16'h1111 * (i + 1)));
    for (int i = 0; i < 4; i++) begin
      rd(8'(QPTR_BASE_OFS + 4 * i), 32'(16'h1111 * (i + 1)), 1'b0);
    end
    `CHK(qptr[3], 16'h4444)
    wr(MAIN_CONTROL_OFS, 16'h0000);
    wr(QPTR_BASE_OFS, 16'hffff);
    rd(QPTR_BASE_OFS, 32'h0000_1111, 1'b0);
    wr(MAIN_CONTROL_OFS, 16'h0008);
    $display("test qptr done");
    for (int i = 0; i < 3; i++) begin
      wr(MAIN_CONTROL_OFS, (i < 2) ? 16'h0010 : 16'h0000);
      #1 `CHK(token_out, (i < 2))
      @(posedge core_clk);
      #1 `CHK(token_out, 1'b0)
    end
    $display("test token done");
    wr(MAIN_CONTROL_OFS, 16'h8000);
    irq(1'b1, 1'b1, 1'b0, 1'b1);
    irq(1'b0, 1'b1, 1'b0, 1'b0);
    irq(1'b1, 1'b0, 1'b1, 1'b1);
    wr(MAIN_CONTROL_OFS, 16'h0000);
    irq(1'b1, 1'b1, 1'b0, 1'b0);
    $display("test irq done");
    c = '0;
    c.filter_upper_bits = 2'b10;
    c.network_interface_select = 1'b1;
    c.vp_bit_count = 3'd3;
    wr(MAIN_CONTROL_OFS, c);
    hdr(18'h2_1234, 3'b000, 16'h0020, 1'b1, 1'b0, 5'h07);
    hdr(18'h0_1234, 3'b000, 16'h0020, 1'b0, 1'b1, 5'h00);
    hdr(18'h3_5234, 3'b000, 16'h0020, 1'b0, 1'b1, 5'h00);
    c.network_interface_select = 1'b0;
    wr(MAIN_CONTROL_OFS, c);
    hdr(18'h3_5234, 3'b000, 16'h0020, 1'b1, 1'b0, 5'h07);
    hdr(18'h0_1235, 3'b000, 16'h0020, 1'b0, 1'b1, 5'h00);
    c.discard_mgmt_cells = 1'b1;
    wr(MAIN_CONTROL_OFS, c);
    hdr(18'h0_1234, 3'b100, 16'h0005, 1'b0, 1'b1, 5'h07);
    hdr(18'h0_1234, 3'b100, 16'h0003, 1'b1, 1'b0, 5'h07);
    hdr(18'h0_1234, 3'b101, 16'h0004, 1'b1, 1'b0, 5'h07);
    hdr(18'h0_1234, 3'b000, 16'h0005, 1'b1, 1'b0, 5'h07);
    c.discard_mgmt_cells = 1'b0;
    wr(MAIN_CONTROL_OFS, c);
    hdr(18'h0_1234, 3'b100, 16'h0005, 1'b1, 1'b0, 5'h07);
    // only the valid count codes are written
    for (int k = 0; k <= int'(VP_COUNT_MAX); k++) begin
      c.vp_bit_count = 3'(k);
      wr(MAIN_CONTROL_OFS, c);
      hdr(18'h0_1234, 3'b000, 16'h0020, 1'b1, 1'b0, 5'((1 << k) - 1));
    end
    $display("test filter done");
    wr(MAIN_CONTROL_OFS, 16'h0040);
    desc(16'h0030, 1'b1);
    wr(MAIN_CONTROL_OFS, 16'h0000);
    desc(16'h0044, 1'b0);
    wr(MAIN_CONTROL_OFS, 16'h0080);
    oam(8'h00, 0);
    oam(8'h80, 1);
    wr(MAIN_CONTROL_OFS, 16'h0000);
    oam(8'h80, 0);
    $display("test desc crc done");
    wr(MAIN_CONTROL_OFS, 16'h0020);
    @(posedge core_clk);
    tx_cell <= 9'h1a5;
    @(posedge core_clk);
    tx_cell <= 9'h05a;
    #1 `CHK(rx_cell, 9'h1a5)
    @(posedge core_clk);
    #1 `CHK(rx_cell, 9'h05a)
    wr(MAIN_CONTROL_OFS, 16'h0000);
    repeat (5) @(posedge core_clk);
    #1 `CHK(rx_cell, 9'h1c3)
    `CHK(loop_clk_sel, 1'b0)
    $display("test loop done");
    wr(MAIN_CONTROL_OFS, 16'h0022);
    wr(QPTR_BASE_OFS, 16'hbeef);
    #1 `CHK(qptr[0], 16'hbeef)
    wr(MAIN_CONTROL_OFS, 16'h0026);
    #1 `CHK(soft_reset, 1'b1)
    @(posedge core_clk);
    #1 `CHK({loop_clk_sel, qptr_wr_en, qptr[0]}, 18'h0_0000)
    rd(MAIN_CONTROL_OFS, 32'h0000_0000, 1'b0);
    rd(QPTR_BASE_OFS, 32'h0000_0000, 1'b0);
    $display("test soft reset done");
    test_done();
  end
endmodule
